/* File: pkg/civp_defs.svh */
// Overview of operation
// - Interrupt lines active low, normal line held until response, fast line follows its source
// - Tie-off high: synchronise interrupt lines to clock
// - Tie-off high: synchronise vector-valid to clock
// - Controller holds aligned vector stable while valid
// - Drive active-low monitor interrupt from core clock
`ifndef CIVP_DEFS_SVH
`define CIVP_DEFS_SVH

// ----------------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------------

`define CIVP_VEC_MSB 31
`define CIVP_VEC_LSB 2
`define CIVP_REQ_N_RST 1'h1
`define CIVP_ACK_RST 1'h0

`endif

/* File: pkg/civp_pkg.sv */
// ----------------------------------------------------------------------------
// Shared types
// ----------------------------------------------------------------------------

`include "civp_defs.svh"

package civp_pkg;

  typedef logic [`CIVP_VEC_MSB:`CIVP_VEC_LSB] civp_vec_t;

  // Controller side states.
  typedef enum logic [1:0] {
    CIVP_C_IDLE,
    CIVP_C_OFFER,
    CIVP_C_RELEASE
  } civp_ctl_e;

endpackage

/* File: pkg/civp_if.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Link between interrupt controller and core port
// ----------------------------------------------------------------------------

interface civp_if;
  import civp_pkg::*;

  logic fast_int_req_n;
  logic normal_int_req_n;
  logic vector_addr_valid;
  civp_vec_t handler_vector_addr;
  logic int_taken_ack;

  modport core (
    input fast_int_req_n,
    input normal_int_req_n,
    input vector_addr_valid,
    input handler_vector_addr,
    output int_taken_ack
  );

  modport ctl (
    output fast_int_req_n,
    output normal_int_req_n,
    output vector_addr_valid,
    output handler_vector_addr,
    input int_taken_ack
  );
endinterface

/* File: design/civp_core_port.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Core-side interrupt and vector port
// ----------------------------------------------------------------------------

module civp_core_port
  import civp_pkg::*;
(
  // Clock, reset and enable.
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic CLK_EN_I,
  // Tie-offs.
  input wire logic INT_LINES_ASYNC_SELECT_I,
  input wire logic VECTOR_VALID_ASYNC_SELECT_I,
  // Core side.
  input wire logic PERF_MONITOR_REQ_I,
  input wire logic CORE_TAKE_I,
  output logic FAST_PENDING_O,
  output logic NORMAL_PENDING_O,
  output logic VECTOR_READY_O,
  output civp_vec_t VECTOR_O,
  output logic PERF_MONITOR_INT_N_O,
  // Link.
  civp_if.core LINK
);

  `include "civp_defs.svh"

  typedef struct packed {
    logic [1:0] fiq_sync;
    logic [1:0] irq_sync;
    logic [1:0] vld_sync;
    logic fast_pend;
    logic normal_pend;
    logic vec_ready;
    civp_vec_t vec;
    logic ack;
    logic vec_used;
    logic pmu_n;
  } civp_core_s;

  civp_core_s r;
  civp_core_s next_r;
  logic fiq_lvl;
  logic irq_lvl;
  logic vld_lvl;

  // ----------------------------------------------------------------------------
  // Line selection
  // ----------------------------------------------------------------------------

  // Only the second synchroniser stage is read when a line is asynchronous.
  always_comb begin
    fiq_lvl = INT_LINES_ASYNC_SELECT_I ? r.fiq_sync[1] : LINK.fast_int_req_n;
    irq_lvl = INT_LINES_ASYNC_SELECT_I ? r.irq_sync[1] : LINK.normal_int_req_n;
    vld_lvl = VECTOR_VALID_ASYNC_SELECT_I ? r.vld_sync[1] : LINK.vector_addr_valid;
  end

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------

  // Pending flags follow the low level; the vector is captured once valid is seen.
  always_comb begin
    next_r = r;
    next_r.fiq_sync = {r.fiq_sync[0], LINK.fast_int_req_n};
    next_r.irq_sync = {r.irq_sync[0], LINK.normal_int_req_n};
    next_r.vld_sync = {r.vld_sync[0], LINK.vector_addr_valid};
    next_r.fast_pend = ~fiq_lvl;
    next_r.normal_pend = ~irq_lvl;
    next_r.ack = 1'h0;
    if (vld_lvl && !r.vec_ready && !r.vec_used) begin
      next_r.vec = LINK.handler_vector_addr;
      next_r.vec_ready = 1'h1;
    end
    // A synchronised valid lags its release, so a spent vector is blocked until valid is seen low.
    if (!vld_lvl) begin
      next_r.vec_used = 1'h0;
    end
    if (CORE_TAKE_I && r.vec_ready && r.normal_pend) begin
      next_r.ack = 1'h1;
      next_r.vec_ready = 1'h0;
      next_r.vec_used = 1'h1;
    end
    if (!vld_lvl && !r.ack) begin
      next_r.vec_ready = 1'h0;
    end
    next_r.pmu_n = ~PERF_MONITOR_REQ_I;
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------

  // Clock enable low freezes all state.
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      r <= '0;
      r.fiq_sync <= {2{`CIVP_REQ_N_RST}};
      r.irq_sync <= {2{`CIVP_REQ_N_RST}};
      r.pmu_n <= `CIVP_REQ_N_RST;
      r.ack <= `CIVP_ACK_RST;
    end else if (CLK_EN_I) begin
      r <= next_r;
    end
  end

  // Outputs come straight from state.
  assign LINK.int_taken_ack = r.ack;
  assign FAST_PENDING_O = r.fast_pend;
  assign NORMAL_PENDING_O = r.normal_pend;
  assign VECTOR_READY_O = r.vec_ready;
  assign VECTOR_O = r.vec;
  assign PERF_MONITOR_INT_N_O = r.pmu_n;

endmodule // civp_core_port

/* File: design/civp_int_ctl.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Interrupt controller end
// ----------------------------------------------------------------------------

module civp_int_ctl
  import civp_pkg::*;
(
  // Clock, reset and enable.
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic CLK_EN_I,
  // User side.
  input wire logic FAST_SRC_I,
  input wire logic NORMAL_SRC_I,
  input wire civp_vec_t HANDLER_I,
  output logic BUSY_O,
  output logic ACKED_O,
  // Link.
  civp_if.ctl LINK
);

  `include "civp_defs.svh"

  typedef struct packed {
    civp_ctl_e st;
    logic fiq_n;
    logic irq_n;
    logic vld;
    civp_vec_t vec;
    logic acked;
  } civp_ctl_s;

  civp_ctl_s r;
  civp_ctl_s next_r;

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------

  // Normal request is held low with the vector until acknowledged.
  always_comb begin
    next_r = r;
    next_r.acked = 1'h0;
    next_r.fiq_n = ~FAST_SRC_I;
    case (r.st)
      CIVP_C_IDLE: begin
        if (NORMAL_SRC_I) begin
          next_r.vec = HANDLER_I;
          next_r.irq_n = 1'h0;
          next_r.vld = 1'h1;
          next_r.st = CIVP_C_OFFER;
        end
      end
      CIVP_C_OFFER: begin
        if (LINK.int_taken_ack) begin
          next_r.irq_n = 1'h1;
          next_r.vld = 1'h0;
          next_r.acked = 1'h1;
          next_r.st = CIVP_C_RELEASE;
        end
      end
      CIVP_C_RELEASE: begin
        next_r.st = CIVP_C_IDLE;
      end
      default: begin
        next_r.st = CIVP_C_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------

  // Vector is only changed while valid is low.
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      r <= '0;
      r.st <= CIVP_C_IDLE;
      r.fiq_n <= `CIVP_REQ_N_RST;
      r.irq_n <= `CIVP_REQ_N_RST;
    end else if (CLK_EN_I) begin
      r <= next_r;
    end
  end

  // Link is driven from flip-flops, so synchronous to the clock.
  assign LINK.fast_int_req_n = r.fiq_n;
  assign LINK.normal_int_req_n = r.irq_n;
  assign LINK.vector_addr_valid = r.vld;
  assign LINK.handler_vector_addr = r.vec;
  assign BUSY_O = (r.st != CIVP_C_IDLE);
  assign ACKED_O = r.acked;

endmodule // civp_int_ctl

/* File: verification/civp_checker.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Link protocol checker
// ----------------------------------------------------------------------------

module civp_checker
  import civp_pkg::*;
(
  // Clock and reset.
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  // Link.
  input wire logic fast_int_req_n,
  input wire logic normal_int_req_n,
  input wire logic vector_addr_valid,
  input wire civp_vec_t handler_vector_addr,
  input wire logic int_taken_ack
);
  // All checks use the core clock and pause in reset.
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);

  // The acknowledge pulse followed by its drop.
  sequence ack_pulse_s;
    int_taken_ack ##1 !int_taken_ack;
  endsequence

  // The acknowledge followed by the released request.
  sequence ack_done_s;
    int_taken_ack ##1 normal_int_req_n;
  endsequence

  ack_pulse_a: assert property (int_taken_ack |-> ack_pulse_s)
    else $error("acknowledge longer than one cycle");
  ack_cause_a: assert property (int_taken_ack |-> vector_addr_valid && !normal_int_req_n)
    else $error("acknowledge without request and vector");
  req_hold_a: assert property (!normal_int_req_n && !int_taken_ack |=> !normal_int_req_n)
    else $error("request dropped before acknowledge");
  req_release_a: assert property (int_taken_ack |=> normal_int_req_n && !vector_addr_valid)
    else $error("request not released after acknowledge");
  vec_stable_a: assert property (vector_addr_valid && $past(vector_addr_valid) |-> $stable(handler_vector_addr))
    else $error("vector changed while valid");
  valid_paired_a: assert property (vector_addr_valid |-> !normal_int_req_n)
    else $error("vector valid without request");
  idle_gap_a: assert property (ack_done_s |=> normal_int_req_n)
    else $error("new request without idle cycle");
endmodule // civp_checker

/* File: verification/tb_core_interrupt_vector_port.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Bench for both link ends
// ----------------------------------------------------------------------------

module tb_core_interrupt_vector_port
  import civp_pkg::*;
;
  logic clk, nrst, sel, take, perf_monitor_unit, fast_src, normal_src, acc, en;
  logic fast_pend, norm_pend, ready, pmu_n, busy, acked;
  civp_vec_t handler, vec_o;
  int checks, mismatches;

  civp_if lnk();

  civp_core_port u_civp_core_port (.CLK_SYS_I(clk), .NRST_I(nrst), .CLK_EN_I(en),
    .INT_LINES_ASYNC_SELECT_I(sel), .VECTOR_VALID_ASYNC_SELECT_I(sel), .PERF_MONITOR_REQ_I(perf_monitor_unit),
    .CORE_TAKE_I(take), .FAST_PENDING_O(fast_pend), .NORMAL_PENDING_O(norm_pend), .VECTOR_READY_O(ready),
    .VECTOR_O(vec_o), .PERF_MONITOR_INT_N_O(pmu_n), .LINK(lnk.core));
  civp_int_ctl u_civp_int_ctl (.CLK_SYS_I(clk), .NRST_I(nrst), .CLK_EN_I(en), .FAST_SRC_I(fast_src),
    .NORMAL_SRC_I(normal_src), .HANDLER_I(handler), .BUSY_O(busy), .ACKED_O(acked), .LINK(lnk.ctl));
  civp_checker u_civp_checker (.CLK_SYS_I(clk), .NRST_I(nrst), .fast_int_req_n(lnk.fast_int_req_n),
    .normal_int_req_n(lnk.normal_int_req_n), .vector_addr_valid(lnk.vector_addr_valid),
    .handler_vector_addr(lnk.handler_vector_addr), .int_taken_ack(lnk.int_taken_ack));

  // Free-running core clock.
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Moves to just after the next rising edge.
  task automatic step;
    @(posedge clk);
    #1;
  endtask

  // Compares and counts.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict.
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Holds reset for three cycles.
  task automatic rst;
    nrst = 1'h0;
    repeat (3) step;
    nrst = 1'h1;
  endtask

  // Core takes the pending request and sees it released.
  task automatic take_it;
    take = 1'h1;
    step;
    take = 1'h0;
    chk("ack", lnk.int_taken_ack, 1'h1);
    step;
    chk("req released", lnk.normal_int_req_n, 1'h1);
    chk("acked", acked, 1'h1);
    step;
  endtask

  // One normal request with its vector, timed from the source.
  task automatic irq(input civp_vec_t vec, input int lat);
    int n;
    n = 0;
    normal_src = 1'h1;
    handler = vec;
    do begin
      step;
      n++;
    end while (!(norm_pend === 1'h1 && ready === 1'h1) && n < 20);
    chk("latency", n, lat);
    if (n >= 20) finish_test();
    chk("vector", vec_o, vec);
    normal_src = 1'h0;
    take_it();
  endtask

  // Main sequence.
  initial begin
    {nrst, sel, take, perf_monitor_unit, fast_src, normal_src, acc} = 7'h00;
    handler = '0;
    en = 1'h1;
    checks = 0;
    mismatches = 0;
    for (int m = 0; m < 2; m++) begin
      sel = m[0];
      rst();
      irq(30'h3FFFFFFF, m ? 4 : 2);
      irq(30'h15555555, m ? 4 : 2);
    end
    // Source drops early, line must stay low.
    normal_src = 1'h1;
    step;
    normal_src = 1'h0;
    repeat (6) step;
    chk("req held", lnk.normal_int_req_n, 1'h0);
    chk("busy", busy, 1'h1);
    take_it();
    chk("busy idle", busy, 1'h0);
    // Take without a pending request is ignored.
    take = 1'h1;
    repeat (4) begin
      step;
      acc = acc | lnk.int_taken_ack;
    end
    take = 1'h0;
    chk("no ack", acc, 1'h0);
    // Fast request is active low on the link.
    fast_src = 1'h1;
    repeat (6) step;
    chk("fast line", lnk.fast_int_req_n, 1'h0);
    chk("fast pend", fast_pend, 1'h1);
    fast_src = 1'h0;
    repeat (6) step;
    chk("fast idle", fast_pend, 1'h0);
    // Monitor interrupt output, frozen while the clock enable is low.
    perf_monitor_unit = 1'h1;
    en = 1'h0;
    repeat (3) step;
    chk("pmu frozen", pmu_n, 1'h1);
    en = 1'h1;
    step;
    chk("pmu low", pmu_n, 1'h0);
    perf_monitor_unit = 1'h0;
    step;
    chk("pmu high", pmu_n, 1'h1);
    finish_test();
  end
endmodule // tb_core_interrupt_vector_port
